// *** core/tcu_top.sv ***
// pulse-width timer/capture unit: counter, two reference/capture registers, wishbone slave
// assumes pad inputs already in the system clock domain timing sense; bus is classic wishbone
//
// Operation
// - a 32-bit count advances by one per selected counting clock when permitted.
// - control bit 0 set lets the count advance; cleared, it holds.
// - control bit 1 picks external clock/gate pin, else system clock.
// - control bit 2 set: falling edges counted, low gates; cleared: rising, high.
// - on system clock, external pin at gating level suppresses increments.
// - active-low driver enable pin shows inverse of control bit 3, registered one cycle after it.
// - bit 4 set stops at low reference; cleared restarts from zero there.
// - bit 5 set raises interrupt on count equal to high or low reference.
// - bit 6 reads pending interrupt; writing one clears it.
// - count held at zero while control bit 7 is set.
// - control bit 8 enables capture; cleared, capture edges are ignored.
// - capture rising edge copies count to high ref, falling to low ref.
// - pulse output rises at high reference count, falls at low reference.
// - reset clears all control bits and the three count/reference registers.
// - all registers, the count included, on system clock; the selected source only enables increments.
`timescale 1ns/1ps

module tcu_top
  import tcu_pkg::*;
#(
  parameter int ADR_W = 15  // wishbone address width
) (
  input  wire logic                  clk_i,      // system clock
  input  wire logic                  rst_n_i,    // async reset, active low
  input  wire logic                  cyc_i,      // bus cycle valid
  input  wire logic                  stb_i,      // transfer strobe
  input  wire logic                  we_i,       // write when high
  input  wire logic [ADR_W-1:0]      adr_i,      // byte address
  input  wire logic [3:0]            sel_i,      // byte selects
  input  wire logic [TCU_DATA_W-1:0] dat_i,      // write data
  output logic      [TCU_DATA_W-1:0] dat_o,      // read data
  output logic                       ack_o,      // normal termination
  output logic                       err_o,      // error termination
  output logic                       rty_o,      // retry, never used
  output logic                       inta_o,     // interrupt request
  input  wire logic                  ext_clk_i,  // external clock/gate pad
  input  wire logic                  capture_i,  // capture pad
  output logic                       pwm_o,      // pulse output
  output logic                       pwm_oe_n_o  // driver enable, active low
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check

  // low four address bits carry the register map
  if (ADR_W < TCU_OFS_W) begin : g_adr_check
    $error("tcu_top: ADR_W must be at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  tcu_ctrl_t             ctrl_q;
  logic [TCU_DATA_W-1:0] count_q;
  logic [TCU_DATA_W-1:0] count_d;
  logic [TCU_DATA_W-1:0] href_q;
  logic [TCU_DATA_W-1:0] lref_q;
  logic [TCU_DATA_W-1:0] rdata_d;
  tcu_sync_t             eclk_q;
  tcu_sync_t             capt_q;
  logic                  ack_q;
  logic                  err_q;
  logic                  inta_q;
  logic                  pwm_q;
  logic                  oe_n_q;
  logic                  match_prev_q;
  logic                  req;
  logic                  acc_ok;
  logic                  wr_go;
  tcu_reg_t              sel_reg;
  logic                  eclk_rise;
  logic                  eclk_fall;
  logic                  eclk_edge;
  logic                  gate_on;
  logic                  tick;
  logic                  href_hit;
  logic                  lref_hit;
  logic                  match_any;
  logic                  irq_event;
  logic                  capt_rise;
  logic                  capt_fall;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  // map a byte address onto a register; anything else is unmapped
  // unaligned and high addresses fall out as unmapped and answer with err_o
  function automatic tcu_reg_t decode_reg(input logic [ADR_W-1:0] adr);
    tcu_reg_t r;
    r = TCU_R_NONE;
    if ((adr >> TCU_OFS_W) == '0) begin
      case (adr[TCU_OFS_W-1:0])
        TCU_OFS_COUNT: r = TCU_R_COUNT;
        TCU_OFS_HREF:  r = TCU_R_HREF;
        TCU_OFS_LREF:  r = TCU_R_LREF;
        TCU_OFS_CTRL:  r = TCU_R_CTRL;
        default:       r = TCU_R_NONE;
      endcase
    end
    return r;
  endfunction : decode_reg

  // new request only when no termination is already on the bus
  assign req     = cyc_i & stb_i & ~ack_q & ~err_q;
  assign sel_reg = decode_reg(adr_i);
  assign acc_ok  = (sel_reg != TCU_R_NONE) && (sel_i == TCU_SEL_FULL);
  assign wr_go   = req & acc_ok & we_i;

  ////////////////////////////////////////////////////////////////////////////////
  // bus terminations

  // one-cycle ack or err per request, rty held low
  // ack_q high blocks a retake, so a held strobe is served every second cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req & acc_ok;
      err_q <= req & ~acc_ok;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign rty_o = 1'b0;

  // read mux, pending flag appears in bit 6
  always_comb begin
    rdata_d = TCU_ZERO32;
    case (decode_reg(adr_i))
      TCU_R_COUNT: rdata_d = count_q;
      TCU_R_HREF:  rdata_d = href_q;
      TCU_R_LREF:  rdata_d = lref_q;
      TCU_R_CTRL:  rdata_d = {{(TCU_DATA_W-TCU_CTRL_W){1'b0}}, ctrl_q};
      default:     rdata_d = TCU_ZERO32;
    endcase
  end

  // read data captured with the ack
  // dat_o keeps the last read word; writes and refused requests leave it alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dat_o <= TCU_ZERO32;
    end else if (req & acc_ok & ~we_i) begin
      dat_o <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pad synchronisers

  // two-stage sync
  // s1 may settle late, so only s2 reads it; edges come from s2 against s3
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eclk_q <= '0;
      capt_q <= '0;
    end else begin
      eclk_q <= '{s1: ext_clk_i, s2: eclk_q.s1, s3: eclk_q.s2};
      capt_q <= '{s1: capture_i, s2: capt_q.s1, s3: capt_q.s2};
    end
  end

  assign eclk_rise = eclk_q.s2 & ~eclk_q.s3;
  assign eclk_fall = ~eclk_q.s2 & eclk_q.s3;
  assign capt_rise = capt_q.s2 & ~capt_q.s3;
  assign capt_fall = ~capt_q.s2 & capt_q.s3;

  ////////////////////////////////////////////////////////////////////////////////
  // count source selection

  assign eclk_edge = ctrl_q.edge_polarity_select ? eclk_fall : eclk_rise;
  // gating level
  // a pad pulse shorter than one cycle can slip past the gate unseen
  assign gate_on   = ctrl_q.edge_polarity_select ? ~eclk_q.s2 : eclk_q.s2;

  assign tick = ctrl_q.count_enable & ~ctrl_q.count_clear &
                (ctrl_q.ext_clock_sel ? eclk_edge : ~gate_on);

  // comparators on the live count
  assign href_hit  = (count_q == href_q);
  assign lref_hit  = (count_q == lref_q);
  assign match_any = href_hit | lref_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // counter

  // next count value
  always_comb begin
    count_d = count_q;
    if (ctrl_q.count_clear) begin
      count_d = TCU_ZERO32;
    end else if (wr_go && sel_reg == TCU_R_COUNT) begin
      count_d = dat_i;
    end else if (tick) begin
      if (lref_hit) begin
        count_d = ctrl_q.single_run ? count_q : TCU_ZERO32;
      end else begin
        count_d = count_q + TCU_ONE32;
      end
    end
  end

  // count updated on the system clock, stepped by the selected source's tick
  // one clock domain: the external source arrives as a synchronised edge that
  // enables the increment, so no count word ever crosses between clocks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= TCU_ZERO32;
    end else begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference/capture registers

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      href_q <= TCU_ZERO32;
    end else if (ctrl_q.capture_enable && capt_rise) begin
      href_q <= count_q;
    end else if (wr_go && sel_reg == TCU_R_HREF) begin
      href_q <= dat_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lref_q <= TCU_ZERO32;
    end else if (ctrl_q.capture_enable && capt_fall) begin
      lref_q <= count_q;
    end else if (wr_go && sel_reg == TCU_R_LREF) begin
      lref_q <= dat_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register and pending flag

  // fire once on entry into a reference match
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match_any;
    end
  end

  // event only when enabled
  // pending sets on entry into a match, not on its level, so a count held
  // at a reference does not re-arm a flag that software has just cleared
  assign irq_event = ctrl_q.irq_enable & match_any & ~match_prev_q;

  // all control bits reset to zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= TCU_CTRL_RST;
    end else begin
      if (wr_go && sel_reg == TCU_R_CTRL) begin
        ctrl_q.count_enable         <= dat_i[TCU_CB_EN];
        ctrl_q.ext_clock_sel        <= dat_i[TCU_CB_ECLK];
        ctrl_q.edge_polarity_select <= dat_i[TCU_CB_POL];
        ctrl_q.out_enable           <= dat_i[TCU_CB_OE];
        ctrl_q.single_run           <= dat_i[TCU_CB_SINGLE];
        ctrl_q.irq_enable           <= dat_i[TCU_CB_IRQEN];
        ctrl_q.count_clear          <= dat_i[TCU_CB_CLR];
        ctrl_q.capture_enable       <= dat_i[TCU_CB_CAPT];
      end
      if (irq_event) begin
        ctrl_q.irq_pending <= 1'b1;
      end else if (wr_go && sel_reg == TCU_R_CTRL && dat_i[TCU_CB_PEND]) begin
        ctrl_q.irq_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt output

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inta_q <= 1'b0;
    end else begin
      inta_q <= ctrl_q.irq_pending & ctrl_q.irq_enable;
    end
  end

  assign inta_o = inta_q;

  ////////////////////////////////////////////////////////////////////////////////
  // pulse output and driver enable

  // rise at high ref, fall at low ref
  // count clear and the low match both win over the high match, so equal
  // references leave the output low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_q <= 1'b0;
    end else if (ctrl_q.count_clear || lref_hit) begin
      pwm_q <= 1'b0;
    end else if (href_hit) begin
      pwm_q <= 1'b1;
    end
  end

  assign pwm_o = pwm_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= ~ctrl_q.out_enable;
    end
  end

  assign pwm_oe_n_o = oe_n_q;

endmodule : tcu_top

// *** core/tcu_pkg.sv ***
// package for the pulse-width timer/capture unit: register map, control layout, reset values
// assumes a 32-bit bus with word-aligned registers and byte addresses on adr_i
package tcu_pkg;

  // register byte offsets
  localparam logic [3:0] TCU_OFS_COUNT = 4'h0;
  localparam logic [3:0] TCU_OFS_HREF  = 4'h4;
  localparam logic [3:0] TCU_OFS_LREF  = 4'h8;
  localparam logic [3:0] TCU_OFS_CTRL  = 4'hc;
  localparam int         TCU_OFS_W     = 4;  // low address bits that pick a register

  // bus widths and constants
  localparam int          TCU_DATA_W    = 32;
  localparam int          TCU_CTRL_W    = 9;
  localparam logic [3:0]  TCU_SEL_FULL  = 4'hf;
  localparam logic [31:0] TCU_ZERO32    = 32'h0000_0000;
  localparam logic [31:0] TCU_ONE32     = 32'h0000_0001;

  // control field positions
  localparam int TCU_CB_EN     = 0;
  localparam int TCU_CB_ECLK   = 1;
  localparam int TCU_CB_POL    = 2;
  localparam int TCU_CB_OE     = 3;
  localparam int TCU_CB_SINGLE = 4;
  localparam int TCU_CB_IRQEN  = 5;
  localparam int TCU_CB_PEND   = 6;
  localparam int TCU_CB_CLR    = 7;
  localparam int TCU_CB_CAPT   = 8;

  // control register layout, msb first
  typedef struct packed {
    logic capture_enable;        // bit 8
    logic count_clear;           // bit 7
    logic irq_pending;           // bit 6
    logic irq_enable;            // bit 5
    logic single_run;            // bit 4
    logic out_enable;            // bit 3
    logic edge_polarity_select;  // bit 2
    logic ext_clock_sel;         // bit 1
    logic count_enable;          // bit 0
  } tcu_ctrl_t;

  localparam tcu_ctrl_t TCU_CTRL_RST = '0;

  // register selector produced by the address decode
  typedef enum logic [2:0] {
    TCU_R_COUNT,
    TCU_R_HREF,
    TCU_R_LREF,
    TCU_R_CTRL,
    TCU_R_NONE
  } tcu_reg_t;

  // synchronised samples of one pad input
  typedef struct packed {
    logic s1;  // first stage
    logic s2;  // stable sample
    logic s3;  // previous stable sample
  } tcu_sync_t;

endpackage : tcu_pkg

// *** testbench/tcu_props.sv ***
// checker for the timer/capture unit: bus answers, driver enable, masking, reset state
// assumes it is bound onto tcu_top and sees only that module's ports
`timescale 1ns/1ps

module tcu_props
  import tcu_pkg::*;
#(
  parameter int ADR_W = 15  // bus address width
) (
  input wire logic                  clk_i,      // system clock
  input wire logic                  rst_n_i,    // reset, active low
  input wire logic                  cyc_i,      // bus cycle
  input wire logic                  stb_i,      // strobe
  input wire logic                  we_i,       // write
  input wire logic [ADR_W-1:0]      adr_i,      // byte address
  input wire logic [3:0]            sel_i,      // byte selects
  input wire logic [TCU_DATA_W-1:0] dat_i,      // write data
  input wire logic [TCU_DATA_W-1:0] dat_o,      // read data
  input wire logic                  ack_o,      // ack
  input wire logic                  err_o,      // error
  input wire logic                  rty_o,      // retry
  input wire logic                  inta_o,     // interrupt
  input wire logic                  ext_clk_i,  // clock/gate pad
  input wire logic                  capture_i,  // capture pad
  input wire logic                  pwm_o,      // pulse output
  input wire logic                  pwm_oe_n_o  // driver enable, low active
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // request accepted on this edge
  wire take = cyc_i & stb_i & ~ack_o & ~err_o;

  sequence s_ctrl_wr;
    take && we_i && adr_i == ADR_W'(TCU_OFS_CTRL) && sel_i == TCU_SEL_FULL;
  endsequence
  sequence s_ctrl_rd;
    take && !we_i && adr_i == ADR_W'(TCU_OFS_CTRL) && sel_i == TCU_SEL_FULL ##1 ack_o;
  endsequence

  a_bus_answer: assert property (take |=> (ack_o ^ err_o))
    else $error("bus request not answered by exactly one termination");
  a_ack_single: assert property (ack_o |=> !ack_o && !err_o)
    else $error("termination held longer than one cycle");
  a_err_bad_sel: assert property (take && sel_i != TCU_SEL_FULL |=> err_o)
    else $error("partial byte select not refused");
  a_rty_quiet: assert property (!rty_o)
    else $error("retry output raised");
  a_oe_tracks: assert property (s_ctrl_wr |-> ##2 pwm_oe_n_o == !$past(dat_i[TCU_CB_OE], 2))
    else $error("driver enable does not follow control bit");
  a_mask_drops: assert property ((s_ctrl_wr ##0 !dat_i[TCU_CB_IRQEN]) |-> ##2 !inta_o)
    else $error("interrupt output not masked");
  a_clear_low: assert property ((s_ctrl_wr ##0 dat_i[TCU_CB_CLR]) |-> ##2 !pwm_o)
    else $error("pulse output high while count held clear");
  a_ctrl_upper: assert property (s_ctrl_rd |-> dat_o[31:9] == '0)
    else $error("unused control bits read nonzero");
  a_reset_idle: assert property ($rose(rst_n_i) |-> pwm_oe_n_o && !pwm_o && !inta_o)
    else $error("outputs not idle after reset");
endmodule : tcu_props

bind tcu_top tcu_props #(.ADR_W(ADR_W)) u_tcu_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .rty_o(rty_o), .inta_o(inta_o), .ext_clk_i(ext_clk_i),
  .capture_i(capture_i), .pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o));

// *** testbench/tcu_pad_model.sv ***
// pad-side model: drives the clock/gate pad and the capture pad
// assumes tasks are called a little after a rising edge of clk_i
`timescale 1ns/1ps

module tcu_pad_model (
  input  wire logic clk_i,      // system clock
  output logic      ext_clk_o,  // clock/gate pad
  output logic      capture_o   // capture pad
);
  initial begin
    ext_clk_o = 1'b0;
    capture_o = 1'b0;
  end

  // static gate level
  task automatic gate(input logic v);
    ext_clk_o = v;
  endtask : gate

  task automatic clocks(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      #1 ext_clk_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 ext_clk_o = 1'b0;
    end
  endtask : clocks

  // one rising then one falling edge
  task automatic capture();
    capture_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 capture_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : capture
endmodule : tcu_pad_model

// *** testbench/test_pwm_timer_capture_unit.sv ***
// self-checking bench for the timer/capture unit
// assumes tcu_top, tcu_pad_model and the bound checker are compiled first
`timescale 1ns/1ps

module test_pwm_timer_capture_unit;
  import tcu_pkg::*;
  typedef struct packed {logic [3:0] ofs; logic [31:0] wr; logic [31:0] rd;} tcu_row_t;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [14:0] adr_i = '0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic        ack_o, err_o, rty_o, inta_o, pwm_o, pwm_oe_n_o, ext_clk, capt, e;
  int          n_fail = 0, comparisons = 0, cycles = 0, hi;
  tcu_row_t rows [4] = '{'{TCU_OFS_COUNT, 32'h1234_5678, 32'h1234_5678},
    '{TCU_OFS_HREF, 32'h0000_0005, 32'h0000_0005}, '{TCU_OFS_LREF, 32'h0000_0010, 32'h0000_0010},
    '{TCU_OFS_CTRL, 32'hffff_fe08, 32'h0000_0008}};

  tcu_top u_tcu_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .rty_o(rty_o), .inta_o(inta_o), .ext_clk_i(ext_clk), .capture_i(capt),
    .pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o));
  tcu_pad_model u_tcu_pad_model (.clk_i(clk_i), .ext_clk_o(ext_clk), .capture_o(capt));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  // one bus cycle, held until ack or err is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    cyc_i = 1'b1;
    stb_i = 1'b1;
    we_i = w;
    adr_i = 15'(a);
    dat_i = d;
    sel_i = s;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o | err_o) && n < 20);
    rd = dat_o;
    e = err_o;
    #1 cyc_i = 1'b0;
    stb_i = 1'b0;
    wt(1);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, TCU_SEL_FULL);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] x);
    bus(1'b0, a, '0, TCU_SEL_FULL);
    chk(rd, x);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    wt(16);
    rst_n_i = 1'b1;
    chk(32'(pwm_oe_n_o), 32'h1);
    foreach (rows[i]) begin
      rdc(rows[i].ofs, 32'h0);
      wr(rows[i].ofs, rows[i].wr);
      rdc(rows[i].ofs, rows[i].rd);
    end
    chk(32'(pwm_oe_n_o), 32'h0);
    wr(TCU_OFS_COUNT, 32'h0);
    wr(TCU_OFS_CTRL, 32'h0000_0029);
    wt(20);
    hi = 0;
    repeat (34) begin
      @(posedge clk_i);
      hi += int'(pwm_o);
    end
    chk(32'(hi), 32'd22);
    chk(32'(inta_o), 32'h1);
    rdc(TCU_OFS_CTRL, 32'h0000_0069);
    // freeze the count with the interrupt still enabled, then clear the flag
    wr(TCU_OFS_CTRL, 32'h0000_0028);
    chk(32'(inta_o), 32'h1);
    wr(TCU_OFS_CTRL, 32'h0000_0068);
    chk(32'(inta_o), 32'h0);
    rdc(TCU_OFS_CTRL, 32'h0000_0028);
    wr(TCU_OFS_CTRL, 32'h0000_0080);
    rdc(TCU_OFS_COUNT, 32'h0);
    chk(32'(pwm_o), 32'h0);
    wr(TCU_OFS_CTRL, 32'h0000_0011);
    wt(30);
    rdc(TCU_OFS_COUNT, 32'h0000_0010);
    wr(TCU_OFS_CTRL, 32'h0000_0080);
    u_tcu_pad_model.gate(1'b1);
    // let the gate level reach the stable sample before counting is enabled
    wt(3);
    wr(TCU_OFS_CTRL, 32'h0000_0011);
    wt(10);
    rdc(TCU_OFS_COUNT, 32'h0);
    wr(TCU_OFS_CTRL, 32'h0000_0015);
    wt(30);
    rdc(TCU_OFS_COUNT, 32'h0000_0010);
    u_tcu_pad_model.gate(1'b0);
    wr(TCU_OFS_CTRL, 32'h0000_0080);
    wr(TCU_OFS_CTRL, 32'h0000_0003);
    u_tcu_pad_model.clocks(5);
    wt(6);
    rdc(TCU_OFS_COUNT, 32'h0000_0005);
    wr(TCU_OFS_CTRL, 32'h0000_0080);
    wr(TCU_OFS_CTRL, 32'h0000_0007);
    u_tcu_pad_model.clocks(3);
    wt(6);
    rdc(TCU_OFS_COUNT, 32'h0000_0003);
    wr(TCU_OFS_CTRL, 32'h0);
    wr(TCU_OFS_COUNT, 32'h0000_0077);
    wr(TCU_OFS_CTRL, 32'h0000_0100);
    u_tcu_pad_model.capture();
    rdc(TCU_OFS_HREF, 32'h0000_0077);
    rdc(TCU_OFS_LREF, 32'h0000_0077);
    wr(TCU_OFS_CTRL, 32'h0);
    wr(TCU_OFS_COUNT, 32'h0000_0099);
    u_tcu_pad_model.capture();
    rdc(TCU_OFS_HREF, 32'h0000_0077);
    bus(1'b0, 4'h2, '0, TCU_SEL_FULL);
    chk(32'(e), 32'h1);
    bus(1'b1, TCU_OFS_HREF, 32'h0000_0055, 4'h3);
    chk(32'(e), 32'h1);
    rdc(TCU_OFS_HREF, 32'h0000_0077);
    summarize();
  end
endmodule : test_pwm_timer_capture_unit
